/* File: exposure_and_storage_regs.sv */
// exposure unit, long exposure and persistent store register bank
//
// Overview of operation
// - read-only quadlet reports sensor width high half, height low half
// - shutter register takes a 12-bit count, 1 to 4095
// - exposure equals selected unit times shutter count
// - unit codes 0..9 mean 1,2,5,10,20,50,100,200,500,1000 us
// - after reset the unit is code 4, twenty microseconds
// - unit changes accepted only when idle, applied at next shutter write
// - model exposure offset in us reported, zero means unknown
// - each feature register shows a read-only presence flag in bit 0
// - long exposure in us occupies bits 6 to 31
// - long exposure writes below model minimum read back as the minimum
// - shutter writes mirror into long exposure, never the reverse
// - long exposure writes take effect at once, even while streaming
// - format, mode or rate write turns long exposure off
// - storage info reports capacity in bytes in bits 8 to 31
// - store data moves in chunks through the transfer window
// - pointer advances by bytes moved after every chunk
// - a chunk write may keep the store busy up to 400 ms
// - erase bit runs up to 30 s, then clears itself
// - idle flag means no capture or sending, needed for unit change
`timescale 1ns/1ns
`include "exposure_storage_consts.svh"
module exposure_and_storage_regs
  import exposure_storage_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = `WRITE_BUSY_CYCLES,
  parameter int unsigned ERASE_CYCLES = `ERASE_CYCLES
) (
  input  wire logic        i_clock,         // 20 MHz system clock
  input  wire logic        i_sys_rst,       // async reset, high
  input  wire logic        i_req_valid,     // quadlet request strobe
  input  wire logic        i_req_write,     // 1 write, 0 read
  input  wire logic [31:0] i_req_addr,      // quadlet address
  input  wire logic [31:0] i_req_wdata,     // write quadlet
  output logic             o_resp_valid,    // answer strobe
  output logic [31:0]      o_resp_rdata,    // read quadlet
  output logic             o_resp_error,    // unmapped address
  input  wire logic        i_camera_idle,   // no capture, no sending
  input  wire logic        i_video_cfg_wr,  // format/mode/rate written
  output logic [25:0]      o_exposure_us,   // exposure in use
  output logic             o_long_active,   // long exposure governs
  input  wire logic        i_chunk_valid,   // chunk passed the window
  input  wire logic [15:0] i_chunk_bytes,   // bytes in that chunk
  output logic             o_chunk_ready,   // store can take a chunk
  output logic             o_flash_write,   // program chunk pulse
  output logic             o_flash_erase,   // erase pulse
  output logic [23:0]      o_flash_ptr      // store byte pointer
);

  // unit code to microseconds, zero for unused codes
  function automatic logic [9:0] unit_us(input logic [3:0] code);
    case (code)
      4'h0:    unit_us = 10'd1;
      4'h1:    unit_us = 10'd2;
      4'h2:    unit_us = 10'd5;
      4'h3:    unit_us = 10'd10;
      4'h4:    unit_us = 10'd20;
      4'h5:    unit_us = 10'd50;
      4'h6:    unit_us = 10'd100;
      4'h7:    unit_us = 10'd200;
      4'h8:    unit_us = 10'd500;
      4'h9:    unit_us = 10'd1000;
      default: unit_us = 10'd0;
    endcase
  endfunction

  // unit times count, widened to the long exposure width
  function automatic logic [25:0] std_exp(input logic [3:0] code,
                                          input logic [11:0] cnt);
    // operands widened first so the product keeps all 22 bits
    std_exp = {4'h0, 22'(unit_us(code)) * 22'(cnt)};
  endfunction

  logic [3:0]   unit_code_ff;
  logic [3:0]   nxt_unit_code;
  logic [3:0]   unit_act_ff;
  logic [3:0]   nxt_unit_act;
  logic [11:0]  count_ff;
  logic [11:0]  nxt_count;
  logic [25:0]  long_ff;
  logic [25:0]  nxt_long;
  logic         long_act_ff;
  logic         nxt_long_act;
  logic [25:0]  exposure_ff;
  logic [25:0]  nxt_exposure;
  logic         wr_en_ff;
  logic         nxt_wr_en;
  logic         rd_en_ff;
  logic         nxt_rd_en;
  logic         erase_ff;
  logic         nxt_erase;
  logic [23:0]  ptr_ff;
  logic [23:0]  nxt_ptr;
  store_state_e state_ff;
  store_state_e nxt_state;
  logic         resp_valid_ff;
  logic         resp_error_ff;
  quadlet_t     rdata_ff;
  quadlet_t     nxt_rdata;
  logic         nxt_error;
  logic         wr;
  logic         rd;
  logic         chunk_take;
  logic         start_write;
  logic         start_erase;
  logic         timer_done;
  logic [11:0]  shut_val;
  logic [25:0]  long_val;

  assign wr = i_req_valid && i_req_write;
  assign rd = i_req_valid && !i_req_write;
  assign shut_val = i_req_wdata[`SHUTTER_MSB:`SHUTTER_LSB];
  assign long_val = i_req_wdata[`LONG_MSB:`LONG_LSB];

  // exposure settings
  always_comb begin
    nxt_unit_code = unit_code_ff;
    nxt_unit_act  = unit_act_ff;
    nxt_count     = count_ff;
    nxt_long      = long_ff;
    nxt_long_act  = long_act_ff;
    if (wr && i_req_addr == `ADDR_UNIT_CTRL && i_camera_idle &&
        unit_us(i_req_wdata[`UNIT_MSB:`UNIT_LSB]) != 10'd0) begin
      nxt_unit_code = i_req_wdata[`UNIT_MSB:`UNIT_LSB];
    end
    if (wr && i_req_addr == `ADDR_SHUTTER) begin
      nxt_count    = (shut_val < `SHUTTER_MIN) ? `SHUTTER_MIN : shut_val;
      nxt_unit_act = unit_code_ff;
      nxt_long     = std_exp(unit_code_ff, nxt_count);
      nxt_long_act = 1'b0;
    end
    if (wr && i_req_addr == `ADDR_LONG_EXP) begin
      nxt_long     = (long_val < `LONG_MIN_US) ? `LONG_MIN_US : long_val;
      nxt_long_act = 1'b1;
    end
    if (i_video_cfg_wr) begin
      nxt_long_act = 1'b0;
    end
    nxt_exposure = nxt_long_act ? nxt_long :
                   std_exp(nxt_unit_act, nxt_count);
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      unit_code_ff <= `UNIT_RESET;
      unit_act_ff  <= `UNIT_RESET;
      count_ff     <= `SHUTTER_RESET;
      long_ff      <= `LONG_RESET;
      long_act_ff  <= 1'b0;
      exposure_ff  <= `LONG_RESET;
    end else begin
      unit_code_ff <= nxt_unit_code;
      unit_act_ff  <= nxt_unit_act;
      count_ff     <= nxt_count;
      long_ff      <= nxt_long;
      long_act_ff  <= nxt_long_act;
      exposure_ff  <= nxt_exposure;
    end
  end

  // chunks pass while enabled and not busy
  assign o_chunk_ready = (state_ff == ST_IDLE) && (wr_en_ff || rd_en_ff);
  assign chunk_take    = i_chunk_valid && o_chunk_ready;
  assign start_write   = chunk_take && wr_en_ff;
  assign start_erase   = wr && i_req_addr == `ADDR_STORE_CTRL &&
                         i_req_wdata[`ERASE_BIT] && state_ff == ST_IDLE;

  // store control and sequencing
  always_comb begin
    nxt_wr_en = wr_en_ff;
    nxt_rd_en = rd_en_ff;
    nxt_erase = erase_ff;
    nxt_ptr   = ptr_ff;
    nxt_state = state_ff;
    if (chunk_take) begin
      nxt_ptr = ptr_ff + {8'h00, i_chunk_bytes};
    end
    if (wr && i_req_addr == `ADDR_STORE_CTRL) begin
      nxt_wr_en = i_req_wdata[`WR_EN_BIT];
      nxt_rd_en = i_req_wdata[`RD_EN_BIT];
      nxt_ptr   = i_req_wdata[`PTR_MSB:`PTR_LSB];
    end
    case (state_ff)
      ST_IDLE: begin
        if (start_erase) begin
          nxt_state = ST_ERASE;
          nxt_erase = 1'b1;
        end else if (start_write) begin
          nxt_state = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (timer_done) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_ERASE: begin
        if (timer_done) begin
          nxt_state = ST_IDLE;
          nxt_erase = 1'b0;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_en_ff <= 1'b0;
      rd_en_ff <= 1'b0;
      erase_ff <= 1'b0;
      ptr_ff   <= 24'h000000;
      state_ff <= ST_IDLE;
    end else begin
      wr_en_ff <= nxt_wr_en;
      rd_en_ff <= nxt_rd_en;
      erase_ff <= nxt_erase;
      ptr_ff   <= nxt_ptr;
      state_ff <= nxt_state;
    end
  end

  // busy time for program and erase
  op_timer u_timer (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_start   (start_write || start_erase),
    .i_count   (start_erase ? 32'(ERASE_CYCLES) : 32'(WRITE_CYCLES)),
    .o_busy    (),
    .o_done    (timer_done)
  );

  // read mux and answer
  always_comb begin
    nxt_rdata = 32'h00000000;
    nxt_error = 1'b0;
    case (i_req_addr)
      `ADDR_MAX_SIZE: begin
        nxt_rdata = {`SENSOR_WIDTH, `SENSOR_HEIGHT};
      end
      `ADDR_UNIT_CTRL: begin
        nxt_rdata[`PRESENT_BIT]           = 1'b1;
        nxt_rdata[`OFFSET_MSB:`OFFSET_LSB] = `EXP_OFFSET_US;
        nxt_rdata[`UNIT_MSB:`UNIT_LSB]     = unit_code_ff;
      end
      `ADDR_LONG_EXP: begin
        nxt_rdata[`PRESENT_BIT]        = 1'b1;
        nxt_rdata[`LONG_MSB:`LONG_LSB] = long_ff;
      end
      `ADDR_STORE_CTRL: begin
        nxt_rdata[`PRESENT_BIT]      = 1'b1;
        nxt_rdata[`WR_EN_BIT]        = wr_en_ff;
        nxt_rdata[`RD_EN_BIT]        = rd_en_ff;
        nxt_rdata[`ERASE_BIT]        = erase_ff;
        nxt_rdata[`PTR_MSB:`PTR_LSB] = ptr_ff;
      end
      `ADDR_STORE_INFO: begin
        nxt_rdata[`PRESENT_BIT]      = 1'b1;
        nxt_rdata[`CAP_MSB:`CAP_LSB] = `STORE_BYTES;
      end
      `ADDR_SHUTTER: begin
        nxt_rdata[`PRESENT_BIT]              = 1'b1;
        nxt_rdata[`SHUTTER_MSB:`SHUTTER_LSB] = count_ff;
      end
      default: begin
        nxt_error = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      resp_valid_ff <= 1'b0;
      resp_error_ff <= 1'b0;
      rdata_ff      <= 32'h00000000;
    end else begin
      resp_valid_ff <= i_req_valid;
      resp_error_ff <= i_req_valid && nxt_error;
      rdata_ff      <= rd ? nxt_rdata : 32'h00000000;
    end
  end

  assign o_resp_valid  = resp_valid_ff;
  assign o_resp_rdata  = rdata_ff;
  assign o_resp_error  = resp_error_ff;
  assign o_exposure_us = exposure_ff;
  assign o_long_active = long_act_ff;
  assign o_flash_write = start_write;
  assign o_flash_erase = start_erase;
  assign o_flash_ptr   = ptr_ff;

  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  a_max_size_read: assert property (
    rd && i_req_addr == `ADDR_MAX_SIZE |=>
    o_resp_rdata == {`SENSOR_WIDTH, `SENSOR_HEIGHT})
    else $error("max size read wrong");
  a_count_range: assert property (
    count_ff >= `SHUTTER_MIN) else $error("shutter count zero");
  a_std_exposure: assert property (
    !long_act_ff |-> o_exposure_us == std_exp(unit_act_ff, count_ff))
    else $error("exposure not unit times count");
  a_unit_deferred: assert property (
    wr && i_req_addr == `ADDR_UNIT_CTRL && !i_camera_idle |=>
    $stable(unit_code_ff) && $stable(unit_act_ff))
    else $error("unit changed while busy");
  a_long_clamped: assert property (
    wr && i_req_addr == `ADDR_LONG_EXP |=> long_ff >= `LONG_MIN_US)
    else $error("long exposure below minimum");
  a_shutter_mirror: assert property (
    wr && i_req_addr == `ADDR_SHUTTER |=>
    long_ff == std_exp(unit_act_ff, count_ff) && !long_act_ff)
    else $error("shutter not mirrored");
  a_long_immediate: assert property (
    wr && i_req_addr == `ADDR_LONG_EXP && !i_video_cfg_wr |=>
    long_act_ff && o_exposure_us == long_ff)
    else $error("long exposure not active");
  a_mode_drops_long: assert property (
    i_video_cfg_wr |=> !long_act_ff) else $error("long stays on");
  a_pointer_step: assert property (
    chunk_take && !(wr && i_req_addr == `ADDR_STORE_CTRL) |=>
    ptr_ff == $past(ptr_ff) + {8'h00, $past(i_chunk_bytes)})
    else $error("pointer step wrong");
  a_erase_selfclear: assert property (
    erase_ff && timer_done |=> !erase_ff && state_ff == ST_IDLE)
    else $error("erase bit not cleared");

  c_long_write: cover property (wr && i_req_addr == `ADDR_LONG_EXP);
  c_chunk_write: cover property (start_write ##1 state_ff == ST_WRITE);
  c_erase_run: cover property (start_erase ##[1:1000] !erase_ff);
endmodule // exposure_and_storage_regs

/* File: exposure_and_storage_regs_tb_top.sv */
// testbench of the exposure and storage register bank
`timescale 1ns/1ns
`include "exposure_storage_consts.svh"
module exposure_and_storage_regs_tb_top;
  import exposure_storage_pkg::*;
  localparam int unsigned WR_CYC = 20;
  localparam int unsigned ER_CYC = 50;
  logic        clock, sys_rst, camera_idle, video_cfg_wr;
  logic        req_valid, req_write, resp_valid, resp_error;
  logic [31:0] req_addr, req_wdata, resp_rdata;
  logic [25:0] exposure_us;
  logic        long_active, chunk_valid, chunk_ready;
  logic        flash_write, flash_erase;
  logic [15:0] chunk_bytes;
  logic [23:0] flash_ptr;
  int          n_fail, n_tests, n_erase;
  int          unit_us [10] = '{1, 2, 5, 10, 20, 50, 100, 200, 500, 1000};

  exposure_and_storage_regs #(
    .WRITE_CYCLES(WR_CYC),
    .ERASE_CYCLES(ER_CYC)
  ) DUT (
    .i_clock(clock), .i_sys_rst(sys_rst),
    .i_req_valid(req_valid), .i_req_write(req_write),
    .i_req_addr(req_addr), .i_req_wdata(req_wdata),
    .o_resp_valid(resp_valid), .o_resp_rdata(resp_rdata),
    .o_resp_error(resp_error), .i_camera_idle(camera_idle),
    .i_video_cfg_wr(video_cfg_wr), .o_exposure_us(exposure_us),
    .o_long_active(long_active), .i_chunk_valid(chunk_valid),
    .i_chunk_bytes(chunk_bytes), .o_chunk_ready(chunk_ready),
    .o_flash_write(flash_write), .o_flash_erase(flash_erase),
    .o_flash_ptr(flash_ptr)
  );

  host_bus_model host (
    .i_clock(clock), .o_req_valid(req_valid), .o_req_write(req_write),
    .o_req_addr(req_addr), .o_req_wdata(req_wdata),
    .i_resp_valid(resp_valid), .i_resp_rdata(resp_rdata),
    .i_resp_error(resp_error), .o_chunk_valid(chunk_valid),
    .o_chunk_bytes(chunk_bytes), .i_chunk_ready(chunk_ready),
    .i_flash_write(flash_write)
  );

  // clock and erase pulse counter
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) if (flash_erase === 1'b1) n_erase++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    host.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    host.xfer(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask
  task automatic settle;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // watchdog far beyond the expected run
  initial begin
    #(50 * 20000);
    n_fail++;
    report_and_stop();
  end

  // main sequence
  initial begin
    logic [31:0] r;
    logic        e;
    logic        w;
    int          k;
    sys_rst = 1'b1;
    camera_idle = 1'b1;
    video_cfg_wr = 1'b0;
    repeat (10) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    chk({6'h0, exposure_us}, 32'd20);
    chk({31'h0, long_active}, 32'h0);
    wr(`ADDR_MAX_SIZE, 32'h0);
    rd_chk(`ADDR_MAX_SIZE, {`SENSOR_WIDTH, `SENSOR_HEIGHT});
    rd_chk(`ADDR_UNIT_CTRL, {8'h80, `EXP_OFFSET_US, 8'h0, `UNIT_RESET});
    rd_chk(`ADDR_LONG_EXP, {6'h20, `LONG_RESET});
    // every unit code times a count of eleven
    for (int c = 0; c < 10; c++) begin
      wr(`ADDR_UNIT_CTRL, 32'(c));
      wr(`ADDR_SHUTTER, 32'd11);
      settle();
      chk({6'h0, exposure_us}, 32'(unit_us[c] * 11));
      rd_chk(`ADDR_LONG_EXP, 32'h80000000 | 32'(unit_us[c] * 11));
      rd_chk(`ADDR_UNIT_CTRL, {8'h80, `EXP_OFFSET_US, 8'h0, 4'(c)});
    end
    // unit change refused while busy, and for bad codes
    camera_idle = 1'b0;
    wr(`ADDR_UNIT_CTRL, 32'h0);
    wr(`ADDR_SHUTTER, 32'd3);
    settle();
    chk({6'h0, exposure_us}, 32'd3000);
    camera_idle = 1'b1;
    wr(`ADDR_UNIT_CTRL, 32'hA);
    rd_chk(`ADDR_UNIT_CTRL, {8'h80, `EXP_OFFSET_US, 8'h0, 4'h9});
    wr(`ADDR_UNIT_CTRL, 32'h0);
    settle();
    chk({6'h0, exposure_us}, 32'd3000);
    wr(`ADDR_SHUTTER, 32'hFFF);
    settle();
    chk({6'h0, exposure_us}, 32'd4095);
    wr(`ADDR_SHUTTER, 32'h0);
    settle();
    chk({6'h0, exposure_us}, 32'd1);
    // long exposure while streaming
    camera_idle = 1'b0;
    wr(`ADDR_LONG_EXP, 32'h5);
    settle();
    chk({31'h0, long_active}, 32'h1);
    chk({6'h0, exposure_us}, {6'h0, `LONG_MIN_US});
    rd_chk(`ADDR_LONG_EXP, {6'h20, `LONG_MIN_US});
    wr(`ADDR_LONG_EXP, 32'h03FFFFFF);
    settle();
    chk({6'h0, exposure_us}, 32'h03FFFFFF);
    rd_chk(`ADDR_LONG_EXP, 32'h83FFFFFF);
    @(posedge clock);
    #1;
    video_cfg_wr = 1'b1;
    @(posedge clock);
    #1;
    video_cfg_wr = 1'b0;
    settle();
    chk({31'h0, long_active}, 32'h0);
    chk({6'h0, exposure_us}, 32'd1);
    camera_idle = 1'b1;
    host.xfer(1'b0, 32'hF1000300, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    // store read session, back to back chunks
    rd_chk(`ADDR_STORE_INFO, {8'h80, `STORE_BYTES});
    wr(`ADDR_STORE_CTRL, 32'h02000000);
    host.chunk(16'd64, 1'b0, w);
    host.chunk(16'd17, 1'b0, w);
    settle();
    chk({8'h0, flash_ptr}, 32'd81);
    rd_chk(`ADDR_STORE_CTRL, 32'h82000051);
    wr(`ADDR_STORE_CTRL, 32'h0);
    host.chunk(16'd5, 1'b1, w);
    settle();
    chk({8'h0, flash_ptr}, 32'd0);
    // store write session, then an append
    wr(`ADDR_STORE_CTRL, 32'h04000000);
    host.chunk(16'd32, 1'b0, w);
    chk({31'h0, w}, 32'h1);
    chk(chunk_ready, 1'b0);
    // look after each edge, once the busy state has settled
    for (k = 0; k < 100 && chunk_ready !== 1'b1; k++) begin
      @(posedge clock);
      #1;
    end
    chk(32'(k >= WR_CYC - 1 && k <= WR_CYC + 2), 32'd1);
    host.chunk(16'd32, 1'b0, w);
    settle();
    chk({8'h0, flash_ptr}, 32'd64);
    wr(`ADDR_STORE_CTRL, 32'h04000041);
    host.chunk(16'd8, 1'b0, w);
    settle();
    chk({8'h0, flash_ptr}, 32'd73);
    wr(`ADDR_STORE_CTRL, 32'h0);
    // last chunk program must finish, erase is refused while busy
    repeat (WR_CYC) @(posedge clock);
    // erase runs, then its bit clears itself
    wr(`ADDR_STORE_CTRL, 32'h01000000);
    chk(n_erase, 32'd1);
    rd_chk(`ADDR_STORE_CTRL, 32'h81000000);
    repeat (ER_CYC + 5) @(posedge clock);
    rd_chk(`ADDR_STORE_CTRL, 32'h80000000);
    report_and_stop();
  end
endmodule // exposure_and_storage_regs_tb_top

/* File: exposure_storage_consts.svh */
// constants of the exposure and storage register bank
`ifndef EXPOSURE_STORAGE_CONSTS_SVH
`define EXPOSURE_STORAGE_CONSTS_SVH
// quadlet addresses, bit 0 of a field is the quadlet msb
`define ADDR_MAX_SIZE      32'hF1000200
`define ADDR_UNIT_CTRL     32'hF1000208
`define ADDR_LONG_EXP      32'hF100020C
`define ADDR_STORE_CTRL    32'hF1000B00
`define ADDR_STORE_INFO    32'hF1000B04
`define ADDR_SHUTTER       32'hF0F0081C
// field positions as hardware bit indexes (31 = quadlet bit 0)
`define PRESENT_BIT        31
`define WIDTH_MSB          31
`define WIDTH_LSB          16
`define HEIGHT_MSB         15
`define HEIGHT_LSB         0
`define OFFSET_MSB         23
`define OFFSET_LSB         12
`define UNIT_MSB           3
`define UNIT_LSB           0
`define LONG_MSB           25
`define LONG_LSB           0
`define SHUTTER_MSB        11
`define SHUTTER_LSB        0
`define WR_EN_BIT          26
`define RD_EN_BIT          25
`define ERASE_BIT          24
`define PTR_MSB            23
`define PTR_LSB            0
`define CAP_MSB            23
`define CAP_LSB            0
// reset values and fixed reports
`define UNIT_RESET         4'h4
`define SHUTTER_RESET      12'h001
`define SHUTTER_MIN        12'h001
`define LONG_RESET         26'h0000014
`define SENSOR_WIDTH       16'h0980
`define SENSOR_HEIGHT      16'h0800
`define EXP_OFFSET_US      12'h01A
`define LONG_MIN_US        26'h000000A
`define STORE_BYTES        24'h010000
// timing
`define CLK_HZ             20000000
`define WRITE_BUSY_MS      400
`define ERASE_S            30
`define WRITE_BUSY_CYCLES  (`WRITE_BUSY_MS * (`CLK_HZ / 1000))
`define ERASE_CYCLES       (`ERASE_S * `CLK_HZ)
`endif

/* File: exposure_storage_pkg.sv */
// types of the exposure and storage register bank
package exposure_storage_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WRITE = 2'b01,
    ST_ERASE = 2'b10
  } store_state_e;
  typedef logic [31:0] quadlet_t;
endpackage

/* File: host_bus_model.sv */
// host side model: quadlet requests and chunk transfers
`timescale 1ns/1ns
module host_bus_model (
  input  wire logic        i_clock,       // system clock
  output logic             o_req_valid,   // request strobe
  output logic             o_req_write,   // 1 write, 0 read
  output logic [31:0]      o_req_addr,    // quadlet address
  output logic [31:0]      o_req_wdata,   // write quadlet
  input  wire logic        i_resp_valid,  // answer strobe
  input  wire logic [31:0] i_resp_rdata,  // read quadlet
  input  wire logic        i_resp_error,  // unmapped address
  output logic             o_chunk_valid, // chunk strobe
  output logic [15:0]      o_chunk_bytes, // bytes in chunk
  input  wire logic        i_chunk_ready, // store takes a chunk
  input  wire logic        i_flash_write  // program pulse
);
  // idle bus at time zero
  initial begin
    o_req_valid = 1'b0;
    o_req_write = 1'b0;
    o_req_addr = 32'h0;
    o_req_wdata = 32'h0;
    o_chunk_valid = 1'b0;
    o_chunk_bytes = 16'h0;
  end

  // one quadlet, answer awaited for a few edges
  task automatic xfer(input logic wr, input logic [31:0] addr,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
    int k;
    rd = 'x;
    err = 'x;
    @(posedge i_clock);
    #1;
    o_req_valid = 1'b1;
    o_req_write = wr;
    o_req_addr = addr;
    o_req_wdata = wd;
    @(posedge i_clock);
    #1;
    o_req_valid = 1'b0;
    // released lines show no stale value
    o_req_addr = ~addr;
    o_req_wdata = ~wd;
    for (k = 0; k < 3 && i_resp_valid !== 1'b1; k++) begin
      @(posedge i_clock);
      #1;
    end
    if (i_resp_valid === 1'b1) begin
      rd = i_resp_rdata;
      err = i_resp_error;
    end
  endtask

  // one chunk through the window
  task automatic chunk(input logic [15:0] n, input bit force_it,
                       output logic wrote);
    int k;
    @(posedge i_clock);
    #1;
    // host waits out the busy time, up to 200 edges, unless force_it is set
    for (k = 0; k < 200 && !force_it && i_chunk_ready !== 1'b1; k++) begin
      @(posedge i_clock);
      #1;
    end
    o_chunk_valid = 1'b1;
    o_chunk_bytes = n;
    #1;
    wrote = i_flash_write;
    @(posedge i_clock);
    #1;
    o_chunk_valid = 1'b0;
    o_chunk_bytes = ~n;
  endtask
endmodule // host_bus_model

/* File: op_timer.sv */
// one-shot busy timer for storage operations
`timescale 1ns/1ns
module op_timer (
  input  wire logic        i_clock,   // system clock
  input  wire logic        i_sys_rst, // async reset, high
  input  wire logic        i_start,   // load and start
  input  wire logic [31:0] i_count,   // cycles to stay busy
  output logic             o_busy,    // counting
  output logic             o_done     // last cycle pulse
);
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;

  // count down to zero after a start
  always_comb begin
    nxt_cnt = cnt_ff;
    if (i_start) begin
      nxt_cnt = (i_count == 32'h0) ? 32'h1 : i_count;
    end else if (cnt_ff != 32'h0) begin
      nxt_cnt = cnt_ff - 32'h1;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_ff <= 32'h0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign o_busy = (cnt_ff != 32'h0);
  assign o_done = (cnt_ff == 32'h1) && !i_start;
endmodule // op_timer
